// file: core/lnctl_clock_divider_field.sv
// Clock output divider: halves the reference per divider step, stopped when off
`timescale 1ns/100ps
module lnctl_clock_divider_field
  import lnctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] sel,
  output logic clk_out
);
  logic [4:0] cnt_q;
  logic out_q;
  logic [4:0] half_w;
  logic wrap_w;

  assign half_w = 5'h01 << (sel - 3'h1);
  assign wrap_w = (cnt_q >= half_w - 5'h01);
  assign clk_out = out_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
      out_q <= 1'b0;
    end else if (sel == CLOCK_DIVIDER_FIELD_OFF || sel > CLOCK_DIVIDER_FIELD_MAX) begin
      cnt_q <= 5'h00;
      out_q <= 1'b0;
    end else if (wrap_w) begin
      cnt_q <= 5'h00;
      out_q <= ~out_q;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

// file: core/lnctl_ocp.sv
// Overcurrent blanking timer and autoretry off-time sequencer
`timescale 1ns/100ps
module lnctl_ocp
  import lnctl_pkg::*;
#(
  parameter int CNT_W = 24
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic over_cur,
  input wire logic [CNT_W-1:0] blank_cyc,
  input wire logic [CNT_W-1:0] off_cyc,
  input wire logic retry_en,
  output logic drv_off,
  output logic fault_evt,
  output logic fault_act
);
  typedef enum logic [3:0] {
    OCP_IDLE = 4'h1,
    OCP_BLANK = 4'h2,
    OCP_OFF = 4'h4,
    OCP_FAULT = 4'h8
  } lnctl_ocp_st_type;

  lnctl_ocp_st_type st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic blank_done_w;
  logic off_done_w;

  assign blank_done_w = (cnt_q >= blank_cyc - CNT_W'(1));
  assign off_done_w = (cnt_q >= off_cyc - CNT_W'(1));
  assign drv_off = (st_q == OCP_OFF);
  assign fault_act = (st_q == OCP_OFF) || (st_q == OCP_FAULT);
  assign fault_evt = (st_q == OCP_BLANK) && over_cur && blank_done_w;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CNT_W'(1);
    case (st_q)
      OCP_IDLE: begin
        cnt_d = '0;
        if (over_cur) begin
          st_d = OCP_BLANK;
        end
      end
      OCP_BLANK: begin
        if (!over_cur) begin
          st_d = OCP_IDLE;
          cnt_d = '0;
        end else if (blank_done_w) begin
          st_d = retry_en ? OCP_OFF : OCP_FAULT;
          cnt_d = '0;
        end
      end
      OCP_OFF: begin
        if (off_done_w) begin
          st_d = OCP_IDLE;
          cnt_d = '0;
        end
      end
      OCP_FAULT: begin
        cnt_d = '0;
        if (!over_cur) begin
          st_d = OCP_IDLE;
        end
      end
      default: begin
        st_d = OCP_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= OCP_IDLE;
      cnt_q <= '0;
    end else if (hold) begin
      st_q <= OCP_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: core/lnctl_pkg.sv
// Package: constants, register map, field layouts and carrier types of the line control block
// Contract
// - Register mode: receive output inverts line, tristates when receive-disable bit set.
// - Pin mode: receive output always inverts line, never disabled.
// - Register mode: clock output rate from divider field, default 14.74MHz, or off.
// - Pin mode: clock output fixed 14.74MHz while enable pin high, else tristated.
// - Interface-select pin high gives register mode, low gives pin mode.
// - Register mode: one bus address bit follows the address/clock-enable pin.
// - Wake-up pulse requests honoured only in register mode.
// - Pin mode: autoretry always on, 500us blanking, 50ms off-time.
// - Pin mode: line output inverts transmit data, aux output inverts aux input.
// - Pin mode: glitch filters bypassed, weak line pull currents off.
// - Pin mode: line wake-up pulls data/wake pin low, not the interrupt output.
// - Pin mode: interrupt output follows driver fault, thermal overload or supply warning.
// - Pin mode: limit-select pin high gives 100mA, low gives 200mA.
// - Pin mode: driver current limit is always active.
// - Register mode: two-bit field selects 50, 100, 200 or 250mA limit.
// - Driver fault only when overcurrent outlasts the blanking time.
// - Register mode: driver fault sets flag and drives interrupt unless masked.
// - Register mode: two-bit field selects 128us, 500us, 1ms or 5ms blanking.
// - Autoretry: driver off after blanking, off for off-time, back on, repeating.
// - Register mode: autoretry enable bit and two-bit off-time field.
// - Pin mode: driver follows the driver-enable input.
// - Enable pin low: driver disabled and registers held at reset values.
package lnctl_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_BLANK_128US_NS = 128000;
  localparam int T_BLANK_500US_NS = 500000;
  localparam int T_BLANK_1MS_NS = 1000000;
  localparam int T_BLANK_5MS_NS = 5000000;
  localparam int T_OFF_10MS_NS = 10000000;
  localparam int T_OFF_20MS_NS = 20000000;
  localparam int T_OFF_50MS_NS = 50000000;
  localparam int T_OFF_100MS_NS = 100000000;

  // Cycles for a time, rounded up, at least one
  function automatic int cyc_of(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_CURRENT_LIMIT = 4'h2;
  localparam logic [3:0] ADDR_INTERRUPT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  localparam int CTL_RX_DIS = 0;
  localparam int CTL_AUX_DIS = 1;
  localparam int CTL_DRV_EN = 2;
  localparam int CTL_WAKE_REQ = 3;
  localparam int CLIM_CL_LSB = 0;
  localparam int CLIM_BL_LSB = 2;
  localparam int CLIM_RETRY = 4;
  localparam int CLIM_OFF_LSB = 5;
  localparam int INT_FAULT = 0;
  localparam int INT_THERM = 1;
  localparam int INT_WARN = 2;
  localparam int INT_WAKE = 3;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] CLOCK_DIVIDER_FIELD_RST = 3'h2;
  localparam logic [7:0] CURRENT_LIMIT_RST = 8'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  localparam logic [2:0] CLOCK_DIVIDER_FIELD_OFF = 3'h0;
  localparam logic [2:0] CLOCK_DIVIDER_FIELD_MAX = 3'h5;
  localparam logic [2:0] CLOCK_DIVIDER_FIELD_PIN = 3'h2;
  localparam logic [1:0] LIMIT_50MA = 2'h0;
  localparam logic [1:0] LIMIT_100MA = 2'h1;
  localparam logic [1:0] LIMIT_200MA = 2'h2;
  localparam logic [1:0] LIMIT_250MA = 2'h3;

  typedef struct packed {
    logic iface_sel;
    logic addr_clken;
    logic limit_sel;
    logic drv_en_in;
    logic tx;
    logic line_lvl;
    logic aux_in;
    logic enable_power_good_pin;
    logic over_cur;
    logic therm;
    logic supply_warn;
    logic wake_det;
  } lnctl_pins_type;

  typedef struct packed {
    logic [1:0] off_time;
    logic retry_en;
    logic [1:0] blank;
    logic [1:0] limit;
  } lnctl_climit_type;
endpackage

// file: core/lnctl_top.sv
// Line driver mode select, pin/register control and overcurrent supervision
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module lnctl_top
  import lnctl_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int BLANK_128US_CYC = cyc_of(T_BLANK_128US_NS),
  parameter int BLANK_500US_CYC = cyc_of(T_BLANK_500US_NS),
  parameter int BLANK_1MS_CYC = cyc_of(T_BLANK_1MS_NS),
  parameter int BLANK_5MS_CYC = cyc_of(T_BLANK_5MS_NS),
  parameter int OFF_10MS_CYC = cyc_of(T_OFF_10MS_NS),
  parameter int OFF_20MS_CYC = cyc_of(T_OFF_20MS_NS),
  parameter int OFF_50MS_CYC = cyc_of(T_OFF_50MS_NS),
  parameter int OFF_100MS_CYC = cyc_of(T_OFF_100MS_NS)
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic IFACE_SEL,
  input wire logic ADDR_BIT_OR_CLOCK_OUT_ENABLE,
  input wire logic BUS_CLOCK_OR_LIMIT_SELECT,
  input wire logic LINE_DRIVER_ENABLE_IN,
  input wire logic TX_DATA_IN,
  input wire logic LINE_LEVEL_IN,
  input wire logic AUX_DIGITAL_INPUT,
  input wire logic ENABLE_POWER_GOOD_PIN,
  input wire logic OVER_CURRENT_IN,
  input wire logic THERMAL_OVERLOAD_IN,
  input wire logic SUPPLY_WARNING_IN,
  input wire logic WAKE_DETECT_IN,
  output logic BUS_ADDR_BIT,
  output logic REG_MODE,
  output logic RX_OUT,
  output logic RX_OE,
  output logic AUX_INPUT_LOGIC_OUT,
  output logic AUX_OE,
  output logic LINE_OUT,
  output logic LINE_OE,
  output logic [1:0] CURRENT_LIMIT_SEL,
  output logic CURRENT_LIMIT_ON,
  output logic FILTER_BYPASS,
  output logic LINE_PULL_ON,
  output logic BUS_DATA_OR_WAKE_FLAG_OUT,
  output logic BUS_DATA_OR_WAKE_FLAG_OE,
  output logic WAKE_INTERRUPT_OUT,
  output logic WAKE_PULSE_GO,
  output logic CLOCK_OUT,
  output logic CLOCK_OUT_OE
);
  localparam int NPIN = $bits(lnctl_pins_type);

  if (CNT_W < 2 || CNT_W > 30) begin : g_bad_w
    $error("CNT_W out of range");
  end
  if (BLANK_5MS_CYC >= (1 << CNT_W) || OFF_100MS_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("Timer counts do not fit CNT_W");
  end
  if (BLANK_128US_CYC < 1 || OFF_10MS_CYC < 1) begin : g_bad_min
    $error("Timer counts must be at least one");
  end

  // Two-stage synchroniser on every pin input
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  lnctl_pins_type raw_w;
  lnctl_pins_type pin_s;

  assign raw_w = '{
    iface_sel: IFACE_SEL,
    addr_clken: ADDR_BIT_OR_CLOCK_OUT_ENABLE,
    limit_sel: BUS_CLOCK_OR_LIMIT_SELECT,
    drv_en_in: LINE_DRIVER_ENABLE_IN,
    tx: TX_DATA_IN,
    line_lvl: LINE_LEVEL_IN,
    aux_in: AUX_DIGITAL_INPUT,
    enable_power_good_pin: ENABLE_POWER_GOOD_PIN,
    over_cur: OVER_CURRENT_IN,
    therm: THERMAL_OVERLOAD_IN,
    supply_warn: SUPPLY_WARNING_IN,
    wake_det: WAKE_DETECT_IN
  };
  assign pin_s = lnctl_pins_type'(sync2_q);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
    end
  end

  logic reg_mode_w;
  logic enabled_w;
  assign reg_mode_w = pin_s.iface_sel;
  assign enabled_w = pin_s.enable_power_good_pin;

  // Register file
  logic [7:0] control_q;
  logic [2:0] clock_divider_field_q;
  lnctl_climit_type climit_q;
  logic [3:0] int_q;
  logic [3:0] int_d;
  logic [3:0] mask_q;
  logic wake_req_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] status_w;
  logic [3:0] event_w;
  logic [3:0] clear_w;
  logic wr_control_w;
  logic wr_clock_divider_field_w;
  logic wr_climit_w;
  logic wr_int_w;
  logic wr_mask_w;

  assign wr_control_w = REG_WR && (REG_ADDR == ADDR_CONTROL);
  assign wr_clock_divider_field_w = REG_WR && (REG_ADDR == ADDR_CLOCK_CONFIG);
  assign wr_climit_w = REG_WR && (REG_ADDR == ADDR_CURRENT_LIMIT);
  assign wr_int_w = REG_WR && (REG_ADDR == ADDR_INTERRUPT);
  assign wr_mask_w = REG_WR && (REG_ADDR == ADDR_IRQ_MASK);

  // Registers held at reset while enable low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      control_q <= CONTROL_RST;
      clock_divider_field_q <= CLOCK_DIVIDER_FIELD_RST;
      climit_q <= lnctl_climit_type'(CURRENT_LIMIT_RST[6:0]);
      mask_q <= IRQ_MASK_RST;
    end else if (!enabled_w) begin
      control_q <= CONTROL_RST;
      clock_divider_field_q <= CLOCK_DIVIDER_FIELD_RST;
      climit_q <= lnctl_climit_type'(CURRENT_LIMIT_RST[6:0]);
      mask_q <= IRQ_MASK_RST;
    end else begin
      if (wr_control_w) begin
        control_q <= REG_WDATA & 8'h07;
      end
      if (wr_clock_divider_field_w) begin
        clock_divider_field_q <= REG_WDATA[2:0];
      end
      if (wr_climit_w) begin
        climit_q <= lnctl_climit_type'(REG_WDATA[6:0]);
      end
      if (wr_mask_w) begin
        mask_q <= REG_WDATA[3:0];
      end
    end
  end

  // Wake pulse request only in register mode
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= wr_control_w && REG_WDATA[CTL_WAKE_REQ] && reg_mode_w && enabled_w;
    end
  end

  // Overcurrent supervision, blanking and off-time per mode
  logic [CNT_W-1:0] blank_sel_w;
  logic [CNT_W-1:0] off_sel_w;
  logic retry_w;
  logic ocp_off_w;
  logic fault_evt_w;
  logic fault_act_w;

  function automatic logic [CNT_W-1:0] pick4(input logic [1:0] s, input int c0,
                                             input int c1, input int c2, input int c3);
    int c;
    case (s)
      2'h0: c = c0;
      2'h1: c = c1;
      2'h2: c = c2;
      default: c = c3;
    endcase
    return c[CNT_W-1:0];
  endfunction

  assign blank_sel_w = reg_mode_w
    ? pick4(climit_q.blank, BLANK_128US_CYC, BLANK_500US_CYC, BLANK_1MS_CYC, BLANK_5MS_CYC)
    : BLANK_500US_CYC[CNT_W-1:0];
  assign off_sel_w = reg_mode_w
    ? pick4(climit_q.off_time, OFF_10MS_CYC, OFF_20MS_CYC, OFF_50MS_CYC, OFF_100MS_CYC)
    : OFF_50MS_CYC[CNT_W-1:0];
  assign retry_w = reg_mode_w ? climit_q.retry_en : 1'b1;

  lnctl_ocp #(
    .CNT_W(CNT_W)
  ) u_ocp (
    .clk(REF_CLK),
    .rst(RST),
    .hold(!enabled_w),
    .over_cur(pin_s.over_cur),
    .blank_cyc(blank_sel_w),
    .off_cyc(off_sel_w),
    .retry_en(retry_w),
    .drv_off(ocp_off_w),
    .fault_evt(fault_evt_w),
    .fault_act(fault_act_w)
  );

  // Sticky interrupt flags, write one to clear, set wins
  logic wake_prev_q;
  logic therm_prev_q;
  logic warn_prev_q;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wake_prev_q <= 1'b0;
      therm_prev_q <= 1'b0;
      warn_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= pin_s.wake_det;
      therm_prev_q <= pin_s.therm;
      warn_prev_q <= pin_s.supply_warn;
    end
  end

  assign event_w[INT_FAULT] = fault_evt_w;
  assign event_w[INT_THERM] = pin_s.therm && !therm_prev_q;
  assign event_w[INT_WARN] = pin_s.supply_warn && !warn_prev_q;
  assign event_w[INT_WAKE] = pin_s.wake_det && !wake_prev_q;
  assign clear_w = wr_int_w ? REG_WDATA[3:0] : 4'h0;
  assign int_d = (reg_mode_w ? event_w : 4'h0) | (int_q & ~clear_w);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      int_q <= 4'h0;
    end else if (!enabled_w) begin
      int_q <= 4'h0;
    end else begin
      int_q <= int_d;
    end
  end

  // Read path, one cycle after the strobe
  assign status_w = {pin_s.addr_clken, pin_s.supply_warn, pin_s.therm, fault_act_w};
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CONTROL: rdata_d = control_q;
        ADDR_CLOCK_CONFIG: rdata_d = {5'h00, clock_divider_field_q};
        ADDR_CURRENT_LIMIT: rdata_d = {1'b0, climit_q};
        ADDR_INTERRUPT: rdata_d = {4'h0, int_q};
        ADDR_IRQ_MASK: rdata_d = {4'h0, mask_q};
        ADDR_STATUS: rdata_d = {3'h0, reg_mode_w, status_w};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Clock output
  logic [2:0] div_sel_w;
  logic clk_div_w;
  logic clk_oe_w;
  // Fixed rate gated by pin in pin mode
  assign div_sel_w = reg_mode_w ? clock_divider_field_q : (pin_s.addr_clken ? CLOCK_DIVIDER_FIELD_PIN : CLOCK_DIVIDER_FIELD_OFF);
  assign clk_oe_w = (div_sel_w != CLOCK_DIVIDER_FIELD_OFF) && (div_sel_w <= CLOCK_DIVIDER_FIELD_MAX);

  lnctl_clock_divider_field u_clock_divider_field (
    .clk(REF_CLK),
    .rst(RST),
    .sel(div_sel_w),
    .clk_out(clk_div_w)
  );

  // Output decode
  logic rx_oe_w;
  logic aux_oe_w;
  logic drv_on_w;
  logic [1:0] limit_w;
  logic irq_w;
  logic wake_flag_w;

  assign rx_oe_w = reg_mode_w ? !control_q[CTL_RX_DIS] : 1'b1;
  assign aux_oe_w = reg_mode_w ? !control_q[CTL_AUX_DIS] : 1'b1;
  assign drv_on_w = enabled_w && pin_s.drv_en_in && !ocp_off_w
    && (reg_mode_w ? control_q[CTL_DRV_EN] : 1'b1);
  assign limit_w = reg_mode_w ? climit_q.limit
    : (pin_s.limit_sel ? LIMIT_100MA : LIMIT_200MA);
  assign irq_w = reg_mode_w ? |(int_q & ~mask_q)
    : (fault_act_w || pin_s.therm || pin_s.supply_warn);
  assign wake_flag_w = !reg_mode_w && pin_s.wake_det;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RX_OUT <= 1'b0;
      RX_OE <= 1'b0;
      AUX_INPUT_LOGIC_OUT <= 1'b0;
      AUX_OE <= 1'b0;
      LINE_OUT <= 1'b0;
      LINE_OE <= 1'b0;
      CURRENT_LIMIT_SEL <= LIMIT_50MA;
      FILTER_BYPASS <= 1'b0;
      LINE_PULL_ON <= 1'b0;
      BUS_DATA_OR_WAKE_FLAG_OE <= 1'b0;
      WAKE_INTERRUPT_OUT <= 1'b0;
      CLOCK_OUT <= 1'b0;
      CLOCK_OUT_OE <= 1'b0;
      BUS_ADDR_BIT <= 1'b0;
      REG_MODE <= 1'b0;
    end else begin
      RX_OUT <= !pin_s.line_lvl;
      RX_OE <= rx_oe_w;
      AUX_INPUT_LOGIC_OUT <= !pin_s.aux_in;
      AUX_OE <= aux_oe_w;
      LINE_OUT <= !pin_s.tx;
      LINE_OE <= drv_on_w;
      CURRENT_LIMIT_SEL <= limit_w;
      FILTER_BYPASS <= !reg_mode_w;
      LINE_PULL_ON <= reg_mode_w;
      BUS_DATA_OR_WAKE_FLAG_OE <= wake_flag_w;
      WAKE_INTERRUPT_OUT <= irq_w;
      CLOCK_OUT <= clk_div_w && clk_oe_w;
      CLOCK_OUT_OE <= clk_oe_w;
      BUS_ADDR_BIT <= reg_mode_w && pin_s.addr_clken;
      REG_MODE <= reg_mode_w;
    end
  end

  assign CURRENT_LIMIT_ON = 1'b1;
  assign BUS_DATA_OR_WAKE_FLAG_OUT = 1'b0;
  assign WAKE_PULSE_GO = wake_req_q;
  assign REG_RDATA = rdata_q;
endmodule

// file: test/lnctl_mcu.sv
// Microcontroller model: register access cycles and strapped pins
`timescale 1ns/100ps
module lnctl_mcu (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  output logic tx,
  output logic drv_en,
  output logic addr_pin
);
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tx = 1'b1;
    drv_en = 1'b0;
    addr_pin = 1'b1;
  end
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// file: test/lnctl_top_monitor.sv
// Checker of mode, pin-path and bus-idle behaviour at the top ports
`timescale 1ns/100ps
module lnctl_top_monitor (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic ADDR_BIT_OR_CLOCK_OUT_ENABLE,
  input wire logic TX_DATA_IN,
  input wire logic LINE_LEVEL_IN,
  input wire logic ENABLE_POWER_GOOD_PIN,
  input wire logic REG_MODE,
  input wire logic RX_OUT,
  input wire logic RX_OE,
  input wire logic LINE_OUT,
  input wire logic LINE_OE,
  input wire logic [1:0] CURRENT_LIMIT_SEL,
  input wire logic CURRENT_LIMIT_ON,
  input wire logic FILTER_BYPASS,
  input wire logic LINE_PULL_ON,
  input wire logic WAKE_PULSE_GO,
  input wire logic CLOCK_OUT_OE
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic pin_mode;
  // Pin syncs need a few edges after reset before outputs mean anything
  assign up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  assign pin_mode = (up_q == 3'h7) && !REG_MODE;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      up_q <= 3'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence pin_steady;
    (pin_mode && ENABLE_POWER_GOOD_PIN && $stable(ADDR_BIT_OR_CLOCK_OUT_ENABLE)
      && $stable(TX_DATA_IN))[*4];
  endsequence
  sequence rx_steady;
    (up_q == 3'h7 && $stable(LINE_LEVEL_IN) && RX_OE)[*4];
  endsequence
  sequence en_held_low;
    (!ENABLE_POWER_GOOD_PIN)[*4];
  endsequence
  a_rx_invert: assert property (rx_steady |-> RX_OUT == !LINE_LEVEL_IN)
    else $error("receive output not inverse of line");
  a_pin_rx_on: assert property (pin_mode && $past(pin_mode) |-> RX_OE)
    else $error("receive output disabled in pin mode");
  a_pin_clk_en: assert property (pin_steady |-> CLOCK_OUT_OE == ADDR_BIT_OR_CLOCK_OUT_ENABLE)
    else $error("clock output enable does not follow pin");
  a_pin_tx_inv: assert property (pin_steady |-> LINE_OUT == !TX_DATA_IN)
    else $error("line output not inverse of transmit data");
  a_pin_filters: assert property (pin_mode && $past(pin_mode) |-> FILTER_BYPASS && !LINE_PULL_ON)
    else $error("filters or pull currents wrong in pin mode");
  a_pin_limit: assert property (pin_mode && $past(pin_mode) |-> CURRENT_LIMIT_SEL inside {2'h1, 2'h2})
    else $error("pin mode current limit out of range");
  a_limit_always: assert property (CURRENT_LIMIT_ON)
    else $error("current limit switched off");
  a_pin_no_pulse: assert property (pin_mode && $past(pin_mode) |-> !WAKE_PULSE_GO)
    else $error("wake pulse request in pin mode");
  a_pulse_single: assert property (WAKE_PULSE_GO |=> !WAKE_PULSE_GO)
    else $error("wake pulse request longer than one cycle");
  a_en_low_off: assert property (en_held_low |-> !LINE_OE)
    else $error("driver on while enable pin low");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read answer cycle");
endmodule

bind lnctl_top lnctl_top_monitor i_lnctl_top_monitor (.REF_CLK, .RST, .REG_RD, .REG_RDATA,
  .ADDR_BIT_OR_CLOCK_OUT_ENABLE, .TX_DATA_IN, .LINE_LEVEL_IN, .ENABLE_POWER_GOOD_PIN,
  .REG_MODE, .RX_OUT, .RX_OE, .LINE_OUT, .LINE_OE, .CURRENT_LIMIT_SEL, .CURRENT_LIMIT_ON,
  .FILTER_BYPASS, .LINE_PULL_ON, .WAKE_PULSE_GO, .CLOCK_OUT_OE);

// file: test/lnctl_top_test.sv
// Testbench of the line control block: register, pin-mode and overcurrent sequences
`timescale 1ns/100ps
module lnctl_top_test
  import lnctl_pkg::*;
;
  localparam int BL[4] = '{4, 8, 12, 16};
  localparam int OF[4] = '{20, 30, 40, 50};
  logic clk, rst, iface_sel, limit_sel, line_lvl, aux_in, enable_power_good_pin, over_cur, therm, warn, wake_det;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] lim_sel;
  logic wr, rd, tx, drv_en, addr_pin, bus_addr_bit, reg_mode, rx_out, rx_oe, aux_out, aux_oe;
  logic line_out, line_oe, lim_on, filt_byp, pull_on, wflag_oe, wirq, wpulse, clk_out, clk_oe;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, e;
  logic prev, seen, wflag;
  lnctl_mcu i_lnctl_mcu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx(tx), .drv_en(drv_en), .addr_pin(addr_pin));
  lnctl_top #(.BLANK_128US_CYC(BL[0]), .BLANK_500US_CYC(BL[1]), .BLANK_1MS_CYC(BL[2]),
    .BLANK_5MS_CYC(BL[3]), .OFF_10MS_CYC(OF[0]), .OFF_20MS_CYC(OF[1]),
    .OFF_50MS_CYC(OF[2]), .OFF_100MS_CYC(OF[3])) i_lnctl_top (
    .REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .IFACE_SEL(iface_sel), .ADDR_BIT_OR_CLOCK_OUT_ENABLE(addr_pin),
    .BUS_CLOCK_OR_LIMIT_SELECT(limit_sel), .LINE_DRIVER_ENABLE_IN(drv_en), .TX_DATA_IN(tx),
    .LINE_LEVEL_IN(line_lvl), .AUX_DIGITAL_INPUT(aux_in), .ENABLE_POWER_GOOD_PIN(enable_power_good_pin),
    .OVER_CURRENT_IN(over_cur), .THERMAL_OVERLOAD_IN(therm), .SUPPLY_WARNING_IN(warn),
    .WAKE_DETECT_IN(wake_det), .BUS_ADDR_BIT(bus_addr_bit), .REG_MODE(reg_mode),
    .RX_OUT(rx_out), .RX_OE(rx_oe), .AUX_INPUT_LOGIC_OUT(aux_out), .AUX_OE(aux_oe),
    .LINE_OUT(line_out), .LINE_OE(line_oe), .CURRENT_LIMIT_SEL(lim_sel),
    .CURRENT_LIMIT_ON(lim_on), .FILTER_BYPASS(filt_byp), .LINE_PULL_ON(pull_on),
    .BUS_DATA_OR_WAKE_FLAG_OUT(wflag), .BUS_DATA_OR_WAKE_FLAG_OE(wflag_oe),
    .WAKE_INTERRUPT_OUT(wirq), .WAKE_PULSE_GO(wpulse), .CLOCK_OUT(clk_out),
    .CLOCK_OUT_OE(clk_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    i_lnctl_mcu.reg_read(a, d);
    cmp_byte(d, exp);
  endtask
  // Overcurrent held until the driver drops and returns; measures both phases
  task automatic oc_run(input int nb, input int no);
    @(posedge clk);
    over_cur <= 1'b1;
    n = 0;
    while (line_oe === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(n >= nb + 2 && n <= nb + 7, 1'b1);
    n = 0;
    while (line_oe !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(n >= no - 1 && n <= no + 3, 1'b1);
    over_cur <= 1'b0;
    tick(4);
  endtask
  initial begin
    {limit_sel, line_lvl, aux_in, over_cur, therm, warn, wake_det} = '0;
    {rst, iface_sel, enable_power_good_pin} = 3'h7;
    tick(16);
    rst <= 1'b0;
    tick(4);
    rd_chk(ADDR_CONTROL, CONTROL_RST);
    rd_chk(ADDR_CLOCK_CONFIG, {5'h00, CLOCK_DIVIDER_FIELD_RST});
    rd_chk(ADDR_CURRENT_LIMIT, CURRENT_LIMIT_RST);
    rd_chk(ADDR_IRQ_MASK, {4'h0, IRQ_MASK_RST});
    rd_chk(4'hF, 8'h00);
    rd_chk(ADDR_STATUS, 8'h18);
    cmp_bit(reg_mode, 1'b1);
    cmp_bit(bus_addr_bit, 1'b1);
    cmp_bit(rx_out, 1'b1);
    i_lnctl_mcu.addr_pin <= 1'b0;
    i_lnctl_mcu.reg_write(ADDR_CONTROL, 8'h03);
    tick(4);
    cmp_bit(bus_addr_bit, 1'b0);
    cmp_bit(rx_oe, 1'b0);
    cmp_bit(aux_oe, 1'b0);
    i_lnctl_mcu.reg_write(ADDR_CONTROL, 8'h08);
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk);
      seen = seen | wpulse;
    end
    cmp_bit(seen, 1'b1);
    for (int s = 0; s < 8; s++) begin
      i_lnctl_mcu.reg_write(ADDR_CLOCK_CONFIG, 8'(s));
      rd_chk(ADDR_CLOCK_CONFIG, 8'(s));
      cmp_bit(clk_oe, s >= 1 && s <= 5);
      e = (s >= 1 && s <= 5) ? (128 >> s) : 0;
      n = 0;
      prev = clk_out;
      repeat (64) begin
        @(posedge clk);
        n += (clk_out !== prev);
        prev = clk_out;
      end
      cmp_bit(n + 1 >= e && n <= e + 1, 1'b1);
    end
    for (int l = 0; l < 4; l++) begin
      i_lnctl_mcu.reg_write(ADDR_CURRENT_LIMIT, 8'(l));
      tick(3);
      cmp_byte({6'h00, lim_sel}, 8'(l));
    end
    i_lnctl_mcu.reg_write(ADDR_CONTROL, 8'h04);
    i_lnctl_mcu.drv_en <= 1'b1;
    i_lnctl_mcu.reg_write(ADDR_CURRENT_LIMIT, 8'h10);
    tick(4);
    for (int p = 0; p < 2; p++) begin
      over_cur <= 1'b1;
      tick(3);
      over_cur <= 1'b0;
      tick(2);
    end
    tick(8);
    cmp_bit(line_oe, 1'b1);
    rd_chk(ADDR_INTERRUPT, 8'h00);
    for (int b = 0; b < 4; b++) begin
      i_lnctl_mcu.reg_write(ADDR_CURRENT_LIMIT, 8'(b * 36 + 16));
      oc_run(BL[b], OF[b]);
      cmp_bit(wirq, 1'b1);
      rd_chk(ADDR_INTERRUPT, 8'h01);
      i_lnctl_mcu.reg_write(ADDR_INTERRUPT, 8'h01);
      tick(2);
      cmp_bit(wirq, 1'b0);
    end
    i_lnctl_mcu.reg_write(ADDR_IRQ_MASK, 8'h01);
    i_lnctl_mcu.reg_write(ADDR_CURRENT_LIMIT, 8'h00);
    over_cur <= 1'b1;
    seen = 1'b1;
    repeat (30) begin
      @(posedge clk);
      seen = seen & line_oe;
    end
    over_cur <= 1'b0;
    cmp_bit(seen, 1'b1);
    cmp_bit(wirq, 1'b0);
    rd_chk(ADDR_INTERRUPT, 8'h01);
    i_lnctl_mcu.reg_write(ADDR_CLOCK_CONFIG, 8'h05);
    enable_power_good_pin <= 1'b0;
    tick(5);
    cmp_bit(line_oe, 1'b0);
    enable_power_good_pin <= 1'b1;
    tick(4);
    rd_chk(ADDR_CLOCK_CONFIG, {5'h00, CLOCK_DIVIDER_FIELD_RST});
    iface_sel <= 1'b0;
    i_lnctl_mcu.tx <= 1'b0;
    aux_in <= 1'b1;
    wake_det <= 1'b1;
    tick(5);
    cmp_bit(reg_mode, 1'b0);
    cmp_bit(filt_byp, 1'b1);
    cmp_bit(line_out, 1'b1);
    cmp_bit(aux_out, 1'b0);
    cmp_bit(aux_oe, 1'b1);
    cmp_bit(wflag_oe, 1'b1);
    cmp_bit(wflag, 1'b0);
    cmp_bit(wirq, 1'b0);
    for (int v = 0; v < 2; v++) begin
      limit_sel <= v[0];
      i_lnctl_mcu.addr_pin <= v[0];
      i_lnctl_mcu.drv_en <= v[0];
      therm <= !v[0];
      line_lvl <= v[0];
      tick(5);
      cmp_byte({6'h00, lim_sel}, v[0] ? 8'h01 : 8'h02);
      cmp_bit(clk_oe, v[0]);
      cmp_bit(line_oe, v[0]);
      cmp_bit(wirq, !v[0]);
      cmp_bit(rx_out, !v[0]);
    end
    warn <= 1'b1;
    tick(5);
    cmp_bit(wirq, 1'b1);
    warn <= 1'b0;
    oc_run(BL[1], OF[2]);
    cmp_bit(wirq, 1'b0);
    finish_test();
  end
endmodule
